//--- src/rcs_pkg.sv
// package for the reset cause and start-up block
package rcs_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] RCS_OFF_CAUSE   = 8'h00;
    localparam logic [7:0] RCS_OFF_STATUS  = 8'h04;
    localparam logic [7:0] RCS_OFF_BORCTL  = 8'h08;
    localparam logic [7:0] RCS_OFF_WDTCTL  = 8'h0C;
    localparam logic [7:0] RCS_OFF_SEQ     = 8'h10;

    // reset_cause_flags field positions
    localparam int RCS_B_OVF = 7;
    localparam int RCS_B_UNF = 6;
    localparam int RCS_B_WDT = 4;
    localparam int RCS_B_PIN = 3;
    localparam int RCS_B_SWR = 2;
    localparam int RCS_B_POR = 1;
    localparam int RCS_B_BOR = 0;
    localparam logic [7:0] RCS_CAUSE_WMASK = 8'hDF;

    // cpu_status field positions
    localparam int RCS_B_TO = 4;
    localparam int RCS_B_PD = 3;

    // brownout_control fields
    localparam int RCS_B_SW_BO_EN = 7;
    localparam int RCS_B_BO_FAST  = 6;
    localparam int RCS_B_BO_READY = 0;
    localparam logic [7:0] RCS_BORCTL_RST = 8'h80;

    localparam logic [4:0] RCS_WD_PRESC_RST = 5'h0B;

    localparam logic [7:0] RCS_CAUSE_RST  = 8'h1C;
    localparam logic [7:0] RCS_STATUS_RST = 8'h18;

    localparam logic [14:0] RCS_RESET_VEC = 15'h0000;
    localparam logic [14:0] RCS_IRQ_VEC   = 15'h0004;

    // timing
    localparam int RCS_CLK_MHZ     = 200;
    localparam int RCS_PUD_MS      = 64;
    localparam int RCS_PUD_CYC     = RCS_PUD_MS * 1000 * RCS_CLK_MHZ;
    localparam int RCS_WDT_BASE_US = 1000;
    localparam int RCS_WDT_CYC     = RCS_WDT_BASE_US * RCS_CLK_MHZ;
    localparam int RCS_CNT_W       = 32;

    localparam logic [1:0] RCS_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RCS_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        RCS_ST_HOLD = 2'b00,
        RCS_ST_WAIT = 2'b01,
        RCS_ST_RUN  = 2'b11,
        RCS_ST_SLP  = 2'b10
    } rcs_state_t;

    typedef struct packed {
        logic por;
        logic bor;
        logic lp_bor;
        logic prog_exit;
        logic sw_reset;
        logic stack_over;
        logic stack_under;
        logic wdt_clear;
        logic sleep_enter;
        logic irq_wake;
    } rcs_evt_t;

    typedef struct packed {
        logic stack_fault_reset_enable;
        logic powerup_delay_enable_n;
        logic pin_reset_enable;
        logic ost_required;
        logic global_irq_enable;
    } rcs_cfg_t;
endpackage : rcs_pkg

//--- src/rcs_reset_cause.sv
// reset merge, start-up sequencing, cause flags and AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause
    import rcs_pkg::*;
#(
    parameter int PUD_CYCLES  = RCS_PUD_CYC,
    parameter int WDT_CYCLES  = RCS_WDT_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire rcs_evt_t    evt,
    input  wire rcs_cfg_t    cfg,
    input  wire logic        external_reset_pin,
    input  wire logic        ost_done,
    input  wire logic        brownout_ready,
    input  wire logic [14:0] wake_pc,
    output logic             core_reset_n,
    output logic             pc_load,
    output logic [14:0]      pc_value,
    output logic             push_return,
    output logic             sleeping,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // two-stage synchronisers for pin and off-domain levels
    logic [1:0] pin_s_r;
    logic [1:0] ost_s_r;
    logic [1:0] rdy_s_r;
    always_ff @(posedge aclk) begin
        pin_s_r <= {pin_s_r[0], external_reset_pin};
        ost_s_r <= {ost_s_r[0], ost_done};
        rdy_s_r <= {rdy_s_r[0], brownout_ready};
    end
    logic pin_n;
    logic ost_ok;
    assign pin_n  = pin_s_r[1];
    assign ost_ok = ost_s_r[1];

    rcs_state_t state_r;
    logic [RCS_CNT_W-1:0] pud_cnt_r;
    logic [RCS_CNT_W-1:0] wdt_cnt_r;
    logic [7:0]  cause_r;
    logic [7:0]  status_r;
    logic [7:0]  borctl_r;
    logic [4:0]  wd_presc_r;

    logic pwr_evt;
    logic bor_evt;
    logic pin_low;
    logic wdt_expire;
    logic stk_rst;
    logic sw_rst;
    logic in_sleep;
    logic wake_irq;
    logic wake_wdt;
    assign pwr_evt    = evt.por | evt.prog_exit;
    assign bor_evt    = evt.bor | evt.lp_bor;
    assign pin_low    = cfg.pin_reset_enable & ~pin_n;
    assign in_sleep   = (state_r == RCS_ST_SLP);
    assign wdt_expire = (wdt_cnt_r >= RCS_CNT_W'(WDT_CYCLES - 1))
                        & (state_r == RCS_ST_RUN || in_sleep);
    assign stk_rst    = (evt.stack_over | evt.stack_under)
                        & cfg.stack_fault_reset_enable;
    assign sw_rst     = evt.sw_reset & (state_r == RCS_ST_RUN);
    assign wake_wdt   = wdt_expire & in_sleep;
    assign wake_irq   = evt.irq_wake & in_sleep;

    logic any_reset;
    // watchdog in sleep wakes instead of resetting
    assign any_reset = pwr_evt | bor_evt | pin_low | sw_rst | stk_rst
                       | (wdt_expire & ~in_sleep);

    // power-up timer counts from the release of power-on or brown-out
    // it runs on while the pin is low, so a late pin release starts at once
    logic pud_done;
    assign pud_done = cfg.powerup_delay_enable_n
                      | (pud_cnt_r >= RCS_CNT_W'(PUD_CYCLES));
    always_ff @(posedge aclk) begin
        if (!aresetn || pwr_evt || bor_evt) begin
            pud_cnt_r <= '0;
        end else if (!pud_done) begin
            pud_cnt_r <= pud_cnt_r + 1'b1;
        end
    end

    // watchdog period counter, restarted by the clear instruction
    always_ff @(posedge aclk) begin
        if (!aresetn || any_reset || evt.wdt_clear || wake_wdt ||
            state_r == RCS_ST_HOLD || state_r == RCS_ST_WAIT) begin
            wdt_cnt_r <= '0;
        end else begin
            wdt_cnt_r <= wdt_cnt_r + 1'b1;
        end
    end

    // sequencer
    logic go_ok;
    assign go_ok = pud_done & (~cfg.ost_required | ost_ok) & ~pin_low;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= RCS_ST_HOLD;
        end else if (any_reset) begin
            state_r <= RCS_ST_HOLD;
        end else begin
            case (state_r)
                RCS_ST_HOLD: state_r <= RCS_ST_WAIT;
                RCS_ST_WAIT: if (go_ok) begin
                    state_r <= RCS_ST_RUN;
                end
                RCS_ST_RUN:  if (evt.sleep_enter) begin
                    state_r <= RCS_ST_SLP;
                end
                RCS_ST_SLP:  if (wake_irq || wake_wdt) begin
                    state_r <= RCS_ST_RUN;
                end
                default:     state_r <= RCS_ST_HOLD;
            endcase
        end
    end

    // core side outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_n <= 1'b0;
            pc_load      <= 1'b0;
            pc_value     <= RCS_RESET_VEC;
            push_return  <= 1'b0;
            sleeping     <= 1'b0;
        end else begin
            core_reset_n <= ~any_reset & (state_r == RCS_ST_RUN
                            || state_r == RCS_ST_SLP
                            || (state_r == RCS_ST_WAIT && go_ok));
            sleeping     <= in_sleep & ~any_reset & ~wake_irq & ~wake_wdt;
            push_return  <= 1'b0;
            pc_load      <= 1'b0;
            // a held pin reset keeps pc_load high until the pin is released
            if (any_reset) begin
                pc_load  <= 1'b1;
                pc_value <= RCS_RESET_VEC;
            end else if (wake_irq && cfg.global_irq_enable) begin
                pc_load     <= 1'b1;
                push_return <= 1'b1;
                pc_value    <= RCS_IRQ_VEC;
            end else if (wake_irq || wake_wdt) begin
                pc_load  <= 1'b1;
                pc_value <= wake_pc + 15'h0001;
            end
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    logic        aw_have_r;
    logic        w_have_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_go;
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RCS_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready;
            s_axi_wready  <= ~w_have_r & ~s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(aw_addr_r) ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic addr_ok(input logic [7:0] a);
        if (a == RCS_OFF_CAUSE || a == RCS_OFF_STATUS || a == RCS_OFF_BORCTL
            || a == RCS_OFF_WDTCTL || a == RCS_OFF_SEQ) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : addr_ok

    logic wr_cause;
    logic wr_bor;
    logic wr_wdt;
    // only byte lane 0 carries register bits
    assign wr_cause = wr_go & w_strb_r[0] & (aw_addr_r == RCS_OFF_CAUSE);
    assign wr_bor   = wr_go & w_strb_r[0] & (aw_addr_r == RCS_OFF_BORCTL);
    assign wr_wdt   = wr_go & w_strb_r[0] & (aw_addr_r == RCS_OFF_WDTCTL);

    // cause flags: firmware write first, hardware events override
    logic [7:0] cause_nxt;
    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = w_data_r[7:0] & RCS_CAUSE_WMASK;
        end
        if (pwr_evt) begin
            cause_nxt = RCS_CAUSE_RST;
            cause_nxt[RCS_B_BOR] = cause_r[RCS_B_BOR];
        end else if (bor_evt) begin
            cause_nxt[RCS_B_OVF] = 1'b0;
            cause_nxt[RCS_B_UNF] = 1'b0;
            cause_nxt[RCS_B_WDT] = 1'b1;
            cause_nxt[RCS_B_PIN] = 1'b1;
            cause_nxt[RCS_B_SWR] = 1'b1;
            cause_nxt[RCS_B_POR] = cause_r[RCS_B_POR];
            cause_nxt[RCS_B_BOR] = 1'b0;
        end else begin
            if (evt.stack_over) begin
                cause_nxt[RCS_B_OVF] = 1'b1;
            end
            if (evt.stack_under) begin
                cause_nxt[RCS_B_UNF] = 1'b1;
            end
            if (wdt_expire && !in_sleep) begin
                cause_nxt[RCS_B_WDT] = 1'b0;
            end
            if (pin_low) begin
                cause_nxt[RCS_B_PIN] = 1'b0;
            end
            if (sw_rst) begin
                cause_nxt[RCS_B_SWR] = 1'b0;
            end
        end
        cause_nxt[5] = 1'b0;
    end

    // time-out and power-down bits
    logic [7:0] status_nxt;
    always_comb begin
        status_nxt = status_r;
        if (pwr_evt || bor_evt) begin
            status_nxt = RCS_STATUS_RST;
        end else if (wdt_expire && !in_sleep) begin
            status_nxt[RCS_B_TO] = 1'b0;
        end else if (wake_wdt) begin
            status_nxt[RCS_B_TO] = 1'b0;
            status_nxt[RCS_B_PD] = 1'b0;
        end else if ((pin_low && in_sleep) || wake_irq) begin
            status_nxt[RCS_B_TO] = 1'b1;
            status_nxt[RCS_B_PD] = 1'b0;
        end else if (evt.wdt_clear && state_r == RCS_ST_RUN) begin
            status_nxt[RCS_B_TO] = 1'b1;
            status_nxt[RCS_B_PD] = 1'b1;
        end else if (evt.sleep_enter && state_r == RCS_ST_RUN) begin
            status_nxt[RCS_B_TO] = 1'b1;
            status_nxt[RCS_B_PD] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // bench reset leaves the power-on flag clear, as after power-on
            cause_r  <= RCS_CAUSE_RST & ~(8'h01 << RCS_B_POR);
            status_r <= RCS_STATUS_RST;
        end else begin
            cause_r  <= cause_nxt;
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            borctl_r <= RCS_BORCTL_RST;
            wd_presc_r <= RCS_WD_PRESC_RST;
        end else begin
            // ready bit is a read-only view of the detector
            if (wr_bor) begin
                borctl_r[RCS_B_SW_BO_EN] <= w_data_r[RCS_B_SW_BO_EN];
                borctl_r[RCS_B_BO_FAST]  <= w_data_r[RCS_B_BO_FAST];
            end
            if (wr_wdt) begin
                wd_presc_r <= w_data_r[5:1];
            end
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RCS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RCS_RESP_OKAY;
                if (s_axi_araddr == RCS_OFF_CAUSE) begin
                    s_axi_rdata <= {24'h00_0000, cause_r};
                end else if (s_axi_araddr == RCS_OFF_STATUS) begin
                    s_axi_rdata <= {24'h00_0000, status_r & 8'h18};
                end else if (s_axi_araddr == RCS_OFF_BORCTL) begin
                    s_axi_rdata <= {24'h00_0000, borctl_r[7:6], 5'h00, rdy_s_r[1]};
                end else if (s_axi_araddr == RCS_OFF_WDTCTL) begin
                    s_axi_rdata <= {24'h00_0000, 2'b00, wd_presc_r, 1'b0};
                end else if (s_axi_araddr == RCS_OFF_SEQ) begin
                    s_axi_rdata <= {30'h0000_0000, state_r};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RCS_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : rcs_reset_cause
`default_nettype wire

//--- test/rcs_reset_cause_monitor.sv
// assertion checker for the reset cause and start-up block
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_monitor
    import rcs_pkg::*;
#(
    parameter int PUD_CYCLES  = 50,
    parameter int WDT_CYCLES  = 40
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire rcs_evt_t    evt,
    input wire rcs_cfg_t    cfg,
    input wire logic        external_reset_pin,
    input wire logic        ost_done,
    input wire logic        core_reset_n,
    input wire logic        pc_load,
    input wire logic [14:0] pc_value,
    input wire logic        push_return,
    input wire logic        sleeping
);
    logic [31:0] pwr_r;
    logic [31:0] rdy_r;
    logic [31:0] run_r;
    // cycles since the last power-type event
    always_ff @(posedge aclk) begin
        if (!aresetn || evt.por || evt.bor || evt.lp_bor || evt.prog_exit) pwr_r <= '0;
        else if (pwr_r < 32'(PUD_CYCLES)) pwr_r <= pwr_r + 32'd1;
    end
    // cycles that pin and oscillator have both been ready
    always_ff @(posedge aclk) begin
        if (!aresetn || (cfg.pin_reset_enable && !external_reset_pin) ||
            (cfg.ost_required && !ost_done)) rdy_r <= '0;
        else if (rdy_r < 32'd100) rdy_r <= rdy_r + 32'd1;
    end
    // running cycles without a watchdog clear
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_reset_n || sleeping || evt.wdt_clear) run_r <= '0;
        else if (run_r < 32'd1000) run_r <= run_r + 32'd1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_core_rst;
        !core_reset_n && pc_load && pc_value == RCS_RESET_VEC;
    endsequence
    sequence s_wake;
        pc_load && core_reset_n;
    endsequence
    a_power_reset: assert property ((evt.por || evt.bor || evt.lp_bor || evt.prog_exit)
        |-> ##[1:2] s_core_rst) else $error("power event gave no reset");
    a_swr_reset: assert property (evt.sw_reset && core_reset_n && !sleeping
        |-> ##[1:2] s_core_rst) else $error("reset instruction gave no reset");
    a_stack_reset: assert property ((evt.stack_over || evt.stack_under) &&
        cfg.stack_fault_reset_enable && core_reset_n && !sleeping |-> ##[1:2] s_core_rst)
        else $error("stack fault gave no reset");
    a_reset_pc: assert property (pc_load && !core_reset_n |-> pc_value == RCS_RESET_VEC)
        else $error("reset pc not zero");
    a_push_vec: assert property (push_return |-> pc_load && pc_value == RCS_IRQ_VEC)
        else $error("push without vector");
    a_wake_src: assert property (s_wake |-> $past(sleeping))
        else $error("pc load while awake");
    a_irq_wake: assert property (evt.irq_wake && sleeping && core_reset_n
        |-> ##[1:2] s_wake) else $error("interrupt did not wake");
    a_wdt_bound: assert property (core_reset_n && !sleeping |-> run_r <= WDT_CYCLES + 4)
        else $error("watchdog did not expire");
    a_pud_hold: assert property ($rose(core_reset_n) && !cfg.powerup_delay_enable_n
        |-> pwr_r >= PUD_CYCLES - 1) else $error("start before power-up delay");
    a_start_ready: assert property ($rose(core_reset_n) |-> rdy_r >= 2)
        else $error("start before pin and oscillator ready");
    a_sleep_enter: assert property (evt.sleep_enter && core_reset_n && !sleeping
        |-> ##[1:2] sleeping) else $error("sleep not entered");
endmodule : rcs_reset_cause_monitor
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the reset cause and start-up block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top
    import rcs_pkg::*;
;
    typedef struct packed { rcs_evt_t e; logic [7:0] c; } rcs_row_t;
    logic aclk, aresetn, external_reset_pin, ost_done, kick_en;
    logic kick_p = 1'b0;
    logic core_reset_n, pc_load, push_return, sleeping;
    logic [14:0] pc_value;
    rcs_evt_t    ev_m, evt;
    rcs_cfg_t    cfg;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int checks, err_total, cyc;
    rcs_row_t rows [7] = '{'{10'h020, 8'h1B}, '{10'h010, 8'h9F}, '{10'h008, 8'h5F},
        '{10'h200, 8'h1D}, '{10'h040, 8'h1D}, '{10'h100, 8'h1E}, '{10'h080, 8'h1E}};

    rcs_reset_cause #(.PUD_CYCLES(50), .WDT_CYCLES(40)) DUT (.aclk, .aresetn, .evt, .cfg,
        .external_reset_pin, .ost_done, .brownout_ready(1'b0), .wake_pc(15'h0123),
        .core_reset_n, .pc_load, .pc_value, .push_return, .sleeping, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    always #2.5 aclk = ~aclk;
    always_comb begin
        evt = ev_m;
        evt.wdt_clear = ev_m.wdt_clear | kick_p;
    end
    // periodic watchdog clear while firmware is meant to be alive
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        kick_p <= kick_en && (cyc[3:0] == 4'h0);
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 0; end
            if (s_axi_wready && !wd) begin wd = 1; s_axi_wvalid <= 0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK("bresp", r, s_axi_bresp)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'b00);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK("rdata", {24'h0, e}, s_axi_rdata)
        `CHK("rresp", r, s_axi_rresp)
    endtask : rd

    task automatic pulse(input rcs_evt_t e);
        ev_m <= e;
        @(posedge aclk);
        ev_m <= '0;
    endtask : pulse

    task automatic wait_pc(input logic [14:0] e, input logic p, input int n);
        int i;
        i = 0;
        do begin @(posedge aclk); i++; end while (!pc_load && i < n);
        `CHK("pc_load", 1'b1, pc_load)
        `CHK("pc_value", e, pc_value)
        `CHK("push_return", p, push_return)
    endtask : wait_pc

    task automatic wait_run();
        while (!core_reset_n) @(posedge aclk);
    endtask : wait_run

    initial begin
        aclk = 0; aresetn = 0; ev_m = '0; cfg = 5'b10110; external_reset_pin = 0;
        ost_done = 0; kick_en = 0; checks = 0; err_total = 0;
        s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; s_axi_awvalid = 0;
        s_axi_wvalid = 0; s_axi_arvalid = 0; s_axi_bready = 1; s_axi_rready = 1;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(RCS_OFF_CAUSE, 8'h14);
        rd(RCS_OFF_STATUS, 8'h18);
        rd(RCS_OFF_BORCTL, 8'h80);
        rd(RCS_OFF_WDTCTL, 8'h16);
        wr(RCS_OFF_BORCTL, 8'h41, RCS_RESP_OKAY);
        rd(RCS_OFF_BORCTL, 8'h40);
        wr(RCS_OFF_WDTCTL, 8'hFF, RCS_RESP_OKAY);
        rd(RCS_OFF_WDTCTL, 8'h3E);
        rd(8'h20, 8'h00, RCS_RESP_SLVERR);
        wr(8'h20, 8'hFF, RCS_RESP_SLVERR);
        repeat (60) @(posedge aclk);
        `CHK("core_reset_n", 1'b0, core_reset_n)
        ost_done <= 1;
        repeat (8) @(posedge aclk);
        `CHK("core_reset_n", 1'b0, core_reset_n)
        external_reset_pin <= 1;
        repeat (6) @(posedge aclk);
        `CHK("core_reset_n", 1'b1, core_reset_n)
        kick_en <= 1;
        rd(RCS_OFF_SEQ, 8'h03);
        foreach (rows[i]) begin
            wr(RCS_OFF_CAUSE, 8'h3F, RCS_RESP_OKAY);
            rd(RCS_OFF_CAUSE, 8'h1F);
            pulse(rows[i].e);
            wait_pc(15'h0000, 1'b0, 6);
            wait_run();
            rd(RCS_OFF_CAUSE, rows[i].c);
        end
        kick_en <= 0;
        wr(RCS_OFF_CAUSE, 8'h1F, RCS_RESP_OKAY);
        wait_pc(15'h0000, 1'b0, 60);
        wait_run();
        rd(RCS_OFF_CAUSE, 8'h0F);
        rd(RCS_OFF_STATUS, 8'h08);
        pulse(10'h002);
        repeat (2) @(posedge aclk);
        `CHK("sleeping", 1'b1, sleeping)
        pulse(10'h001);
        wait_pc(15'h0124, 1'b0, 6);
        rd(RCS_OFF_STATUS, 8'h10);
        rd(RCS_OFF_CAUSE, 8'h0F);
        cfg.global_irq_enable <= 1;
        pulse(10'h002);
        repeat (2) @(posedge aclk);
        pulse(10'h001);
        wait_pc(RCS_IRQ_VEC, 1'b1, 6);
        cfg.global_irq_enable <= 0;
        pulse(10'h002);
        wait_pc(15'h0124, 1'b0, 60);
        rd(RCS_OFF_STATUS, 8'h00);
        pulse(10'h002);
        repeat (2) @(posedge aclk);
        external_reset_pin <= 0;
        wait_pc(15'h0000, 1'b0, 8);
        external_reset_pin <= 1;
        wait_run();
        rd(RCS_OFF_CAUSE, 8'h07);
        rd(RCS_OFF_STATUS, 8'h10);
        kick_en <= 1;
        wr(RCS_OFF_CAUSE, 8'h1F, RCS_RESP_OKAY);
        external_reset_pin <= 0;
        wait_pc(15'h0000, 1'b0, 8);
        external_reset_pin <= 1;
        wait_run();
        rd(RCS_OFF_CAUSE, 8'h17);
        cfg.stack_fault_reset_enable <= 0;
        pulse(10'h010);
        repeat (4) @(posedge aclk);
        `CHK("core_reset_n", 1'b1, core_reset_n)
        give_verdict();
    end
endmodule : tb_top

bind rcs_reset_cause rcs_reset_cause_monitor #(.PUD_CYCLES(PUD_CYCLES),
    .WDT_CYCLES(WDT_CYCLES)) u_mon (.aclk, .aresetn, .evt, .cfg, .external_reset_pin,
    .ost_done, .core_reset_n, .pc_load, .pc_value, .push_return, .sleeping);
`default_nettype wire
